// ==== src/rst_irq_pkg.sv ====
/*
  Constants for the reset gathering and interrupt priority block: register
  indices, field positions, reset values, vectors and timing counts.
  Assumes a word-wide classic Wishbone slave where byte address = 4 * index.
*/
// Function
// - reset sequence starts at first clock edge after pin release; the code drops reset_o on the third edge, after the two-flop synchroniser
// - enabled low-voltage detector asserts internal reset while supply is low
// - nonvolatile options bit 0 enables low-voltage reset when programmed
// - writing zero to bit 0 at 3FF0 restarts the watchdog
// - watchdog time-out resets the whole controller
// - watchdog reset keeps the operating-mode selection unchanged
// - watchdog on after reset; zero to option bit 6 disables it permanently
// - mask bit set blocks every maskable request from the core
// - taking an interrupt stacks registers and sets the mask bit
// - return from interrupt restores registers and resumes execution
// - requests wait for instruction end, then are sampled if unmasked
// - fixed priority and vectors from reset 3FFE down to keypad 3FF0
// - software trap ignores mask, yields to requests pending at its fetch
// - software trap vectors through 3FFC and 3FFD
// - option bit 7 selects falling-edge (1) or low-level (0) pin sensing
// - pin condition raises external request, taken unmasked, vector 3FFA
// - level mode recognises a further request while the line stays low
// - external latch cleared early in service; one more pulse can latch
// - line match with enable raises sync request, vector 3FF8
// - sync request latch clears itself when its vector is fetched
// - every reset sends execution to vector 3FFE and sets the mask
// - power-on holds reset 4064 cycles, longer while pin stays low
package rst_irq_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [13:0] OPTION_CONTROL_IDX = 14'h001D;
  localparam logic [13:0] LINE_IRQ_COUNT_IDX = 14'h000E;
  localparam logic [13:0] WDOG_CLEAR_IDX     = 14'h3FF0;
  localparam logic [13:0] RESET_STATUS_IDX   = 14'h0020;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          EDGE_SEL_BIT  = 7;
  localparam int          WDOG_EN_BIT   = 6;
  localparam int          WDOG_CLR_BIT  = 0;
  localparam int          LINE_EN_BIT   = 7;
  localparam int          LVR_OPT_BIT   = 0;
  localparam logic [7:0]  OPTION_RESET  = 8'h40;
  localparam logic [7:0]  LINE_RESET    = 8'h02;

  // ---------------------------------------------------------------
  // vectors, highest priority first
  // ---------------------------------------------------------------
  localparam logic [15:0] VEC_RESET   = 16'h3FFE;
  localparam logic [15:0] VEC_SOFT    = 16'h3FFC;
  localparam logic [15:0] VEC_EXT     = 16'h3FFA;
  localparam logic [15:0] VEC_SYNC    = 16'h3FF8;
  localparam logic [15:0] VEC_TIMER   = 16'h3FF6;
  localparam logic [15:0] VEC_CORE_TIMER_SOURCE  = 16'h3FF4;
  localparam logic [15:0] VEC_SERIAL  = 16'h3FF2;
  localparam logic [15:0] VEC_KEYPAD  = 16'h3FF0;

  // ---------------------------------------------------------------
  // timing counts in processor cycles
  // ---------------------------------------------------------------
  localparam int          POR_CYCLES    = 4064;
  localparam int          WDOG_CYCLES   = 65536;
  localparam logic [2:0]  STRETCH_CYCLES = 3'h4;

  // hardware request sources, bit 0 is the highest priority
  localparam int          NUM_SRC = 6;

endpackage : rst_irq_pkg

// ==== src/level_sync.sv ====
/*
  Two-flop synchroniser for a group of asynchronous levels.
  Assumes the inputs change slowly compared to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int       WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk_i,      // processor clock
  input  wire logic             sys_rst_i,  // synchronous reset
  input  wire logic [WIDTH-1:0] async_i,    // asynchronous levels
  output logic      [WIDTH-1:0] sync_o      // synchronised levels
);

  logic [WIDTH-1:0] meta;

  // first stage is read only by the second stage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta   <= INIT;
      sync_o <= INIT;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule : level_sync
`default_nettype wire

// ==== src/reset_irq_ctrl.sv ====
/*
  Reset gathering, watchdog and interrupt priority logic with a Wishbone
  register slave. Assumes a core that pulses boundary_i at each instruction
  end and accepts take_o / vector_o / set_mask_o as its interrupt request.
*/
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module reset_irq_ctrl
  import rst_irq_pkg::*;
#(
  parameter int POR_COUNT  = POR_CYCLES,
  parameter int WDOG_COUNT = WDOG_CYCLES
) (
  input  wire logic        clk_i,            // 20 MHz processor clock
  input  wire logic        sys_rst_i,        // power-on, synchronous, high
  // wishbone slave
  input  wire logic        cyc_i,            // bus cycle
  input  wire logic        stb_i,            // strobe
  input  wire logic        we_i,             // write enable
  input  wire logic [15:0] adr_i,            // byte address
  input  wire logic [3:0]  sel_i,            // byte lanes
  input  wire logic [31:0] dat_i,            // write data
  output logic      [31:0] dat_o,            // read data
  output logic             ack_o,            // acknowledge
  // reset sources
  input  wire logic        rst_pin_n_i,      // external reset pin
  input  wire logic        lvd_low_i,        // supply comparator, high = low
  input  wire logic [7:0]  nv_options_i,     // nonvolatile options byte
  input  wire logic        mode_strap_i,     // operating mode selection
  // interrupt sources
  input  wire logic        irq_n_i,          // external interrupt pin
  input  wire logic [6:0]  line_counter_i,   // horizontal line counter
  input  wire logic        timer_req_i,      // programmable timer request
  input  wire logic        core_timer_source_req_i,     // core timer request
  input  wire logic        serial_req_i,     // serial bus request
  input  wire logic        keypad_req_i,     // keyboard request
  // core handshake
  input  wire logic        i_mask_i,         // condition code mask bit
  input  wire logic        boundary_i,       // instruction complete pulse
  input  wire logic        trap_fetch_i,     // software trap fetched pulse
  input  wire logic        trap_exec_i,      // boundary is a software trap
  input  wire logic        rti_i,            // return from interrupt pulse
  output logic             reset_o,          // internal reset, high
  output logic             take_o,           // interrupt taken pulse
  output logic      [15:0] vector_o,         // vector address
  output logic             set_mask_o,       // set mask request
  output logic             in_service_o,     // service routine running
  output logic             mode_o            // held operating mode
);

  // ---------------------------------------------------------------
  // types and helpers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {RUN, HOLD} rst_state_type;

  // index of the highest-priority set bit, NUM_SRC when none
  function automatic logic [2:0] pick(input logic [NUM_SRC-1:0] req);
    logic [2:0] idx;
    idx = 3'(NUM_SRC);
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (req[k]) idx = 3'(k);
    end
    return idx;
  endfunction : pick

  function automatic logic [15:0] vec_of(input logic [2:0] idx);
    case (idx)
      3'h0:    return VEC_EXT;
      3'h1:    return VEC_SYNC;
      3'h2:    return VEC_TIMER;
      3'h3:    return VEC_CORE_TIMER_SOURCE;
      3'h4:    return VEC_SERIAL;
      default: return VEC_KEYPAD;
    endcase
  endfunction : vec_of

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [3:0] sync_q;
  level_sync #(.WIDTH(4), .INIT(4'h3)) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({lvd_low_i, nv_options_i[LVR_OPT_BIT], irq_n_i, rst_pin_n_i}),
    .sync_o    (sync_q)
  );
  logic pin_low, irq_low, lvr_en, lvr_hit, irq_low_d;
  assign pin_low = ~sync_q[0];
  assign irq_low = ~sync_q[1];
  assign lvr_en  = sync_q[2];
  assign lvr_hit = lvr_en & sync_q[3];

  // ---------------------------------------------------------------
  // reset gathering
  // ---------------------------------------------------------------
  logic [12:0]   por_cnt;
  logic          por_busy;
  logic [2:0]    stretch;
  logic          wd_fire;
  logic          rst_all;
  rst_state_type rst_state;
  assign por_busy = por_cnt != 13'(POR_COUNT);
  assign rst_all  = sys_rst_i | reset_o;

  // power-on delay counts from oscillator start
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) por_cnt <= '0;
    else if (por_busy) por_cnt <= por_cnt + 13'h1;
  end

  // watchdog reset is stretched so every block sees it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) stretch <= '0;
    else if (wd_fire) stretch <= STRETCH_CYCLES;
    else if (stretch != 3'h0) stretch <= stretch - 3'h1;
  end

  // one combined reset, released on the edge after the last source ends
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reset_o   <= 1'b1;
      rst_state <= HOLD;
    end else begin
      case (rst_state)
        RUN: if (pin_low | lvr_hit | wd_fire) begin
          reset_o   <= 1'b1;
          rst_state <= HOLD;
        end
        HOLD: if (!(por_busy | pin_low | lvr_hit | wd_fire | stretch != 3'h0)) begin
          reset_o   <= 1'b0;
          rst_state <= RUN;
        end
        default: rst_state <= HOLD;
      endcase
    end
  end

  // mode follows the strap only for pin and power-on resets
  always_ff @(posedge clk_i) begin
    if (sys_rst_i | por_busy | pin_low) mode_o <= mode_strap_i;
  end

  // ---------------------------------------------------------------
  // option, line count and watchdog
  // ---------------------------------------------------------------
  logic [7:0]  option_q;
  logic [7:0]  line_q;
  logic [16:0] wd_cnt;
  logic        wr_opt, wr_line, wr_wdog;
  logic [13:0] idx_q;
  assign idx_q   = adr_i[15:2];
  assign wr_opt  = cyc_i & stb_i & we_i & ~ack_o & sel_i[0] & idx_q == OPTION_CONTROL_IDX;
  assign wr_line = cyc_i & stb_i & we_i & ~ack_o & sel_i[0] & idx_q == LINE_IRQ_COUNT_IDX;
  assign wr_wdog = cyc_i & stb_i & we_i & ~ack_o & sel_i[0] & idx_q == WDOG_CLEAR_IDX;

  // watchdog enable can only be cleared by software
  always_ff @(posedge clk_i) begin
    if (rst_all) option_q <= OPTION_RESET;
    else if (wr_opt) begin
      option_q[EDGE_SEL_BIT] <= dat_i[EDGE_SEL_BIT];
      option_q[WDOG_EN_BIT]  <= option_q[WDOG_EN_BIT] & dat_i[WDOG_EN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) line_q <= LINE_RESET;
    else if (wr_line) line_q <= dat_i[7:0];
  end

  // free-running watchdog, restarted by a zero in the clear bit
  assign wd_fire = ~reset_o & option_q[WDOG_EN_BIT] & wd_cnt == 17'(WDOG_COUNT - 1);
  always_ff @(posedge clk_i) begin
    if (rst_all | wd_fire) wd_cnt <= '0;
    else if (wr_wdog & ~dat_i[WDOG_CLR_BIT]) wd_cnt <= '0;
    else if (option_q[WDOG_EN_BIT]) wd_cnt <= wd_cnt + 17'h1;
  end

  // ---------------------------------------------------------------
  // request latches
  // ---------------------------------------------------------------
  logic       ext_latch, sync_latch, match_d;
  logic       line_match;
  logic [2:0] grant;
  logic       clr_ext, clr_sync;
  assign line_match = line_q[LINE_EN_BIT] & line_counter_i == line_q[6:0];
  assign clr_ext    = take_o & grant == 3'h0;
  assign clr_sync   = take_o & grant == 3'h1;

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      irq_low_d <= 1'b0;
      match_d   <= 1'b0;
    end else begin
      irq_low_d <= irq_low;
      match_d   <= line_match;
    end
  end

  // a new falling edge wins over the clear at vector fetch
  always_ff @(posedge clk_i) begin
    if (rst_all) ext_latch <= 1'b0;
    else if (option_q[EDGE_SEL_BIT] & irq_low & ~irq_low_d) ext_latch <= 1'b1;
    else if (clr_ext) ext_latch <= 1'b0;
  end

  // cleared by its own vector fetch, no software step needed
  always_ff @(posedge clk_i) begin
    if (rst_all) sync_latch <= 1'b0;
    else if (line_match & ~match_d) sync_latch <= 1'b1;
    else if (clr_sync) sync_latch <= 1'b0;
  end

  // ---------------------------------------------------------------
  // arbitration at instruction boundaries
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] pend, trap_snap;
  logic               ext_req;
  // level mode keeps asking while a wired-OR line stays low
  assign ext_req = option_q[EDGE_SEL_BIT] ? ext_latch : irq_low;
  assign pend    = {keypad_req_i, serial_req_i, core_timer_source_req_i,
                    timer_req_i, sync_latch, ext_req};

  // requests already pending when a trap is fetched go first
  always_ff @(posedge clk_i) begin
    if (rst_all) trap_snap <= '0;
    else if (trap_fetch_i) trap_snap <= pend;
    else if (boundary_i) trap_snap <= '0;
  end

  // one take per boundary; requests only wait, never abort
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      take_o     <= 1'b0;
      vector_o   <= VEC_RESET;
      set_mask_o <= 1'b1;
      grant      <= 3'(NUM_SRC);
    end else begin
      take_o     <= 1'b0;
      set_mask_o <= 1'b0;
      grant      <= 3'(NUM_SRC);
      if (boundary_i) begin
        if (!i_mask_i && (trap_exec_i ? |(trap_snap & pend) : |pend)) begin
          take_o     <= 1'b1;
          set_mask_o <= 1'b1;
          grant      <= pick(trap_exec_i ? trap_snap & pend : pend);
          vector_o   <= vec_of(pick(trap_exec_i ? trap_snap & pend : pend));
        end else if (trap_exec_i) begin
          take_o     <= 1'b1;
          set_mask_o <= 1'b1;
          vector_o   <= VEC_SOFT;
        end
      end
    end
  end

  // service routine flag, ended by return from interrupt
  always_ff @(posedge clk_i) begin
    if (rst_all) in_service_o <= 1'b0;
    else if (take_o) in_service_o <= 1'b1;
    else if (rti_i) in_service_o <= 1'b0;
  end

  // ---------------------------------------------------------------
  // wishbone slave, one wait state, unmapped reads return zero
  // ---------------------------------------------------------------
  logic [3:0] cause;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) cause <= 4'h1;
    else if (rst_state == RUN) begin
      if (pin_low) cause <= 4'h2;
      else if (lvr_hit) cause <= 4'h4;
      else if (wd_fire) cause <= 4'h8;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= '0;
      if (cyc_i & stb_i & ~we_i & ~ack_o) begin
        case (idx_q)
          OPTION_CONTROL_IDX: dat_o <= {24'h0, option_q[7:6], 6'h0};
          LINE_IRQ_COUNT_IDX: dat_o <= {24'h0, line_q};
          RESET_STATUS_IDX:   dat_o <= {24'h0, sync_latch, ext_latch, lvr_en,
                                        in_service_o, cause};
          default:            dat_o <= '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_mask_blocks: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_o && vector_o != VEC_SOFT |-> !$past(i_mask_i))
    else $error("maskable request taken while masked");

  // an internal reset in the same cycle as a take clears the service flag, so skip that case
  a_take_sets_mask: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_o && !rst_all |-> set_mask_o ##1 in_service_o)
    else $error("take without mask set or service flag");

  a_only_boundary: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    take_o |-> $past(boundary_i))
    else $error("interrupt taken mid-instruction");

  a_trap_unmasked: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !rst_all && boundary_i && trap_exec_i && i_mask_i |=> take_o && vector_o == VEC_SOFT)
    else $error("software trap not vectored");

  a_ext_first: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !rst_all && boundary_i && !i_mask_i && !trap_exec_i && ext_req
    |=> take_o && vector_o == VEC_EXT)
    else $error("external request lost priority");

  a_wdog_resets: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wd_fire |=> reset_o [*4])
    else $error("watchdog time-out without held reset");

  a_wdog_stays_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !option_q[WDOG_EN_BIT] && !rst_all |=> !option_q[WDOG_EN_BIT])
    else $error("watchdog re-enabled without reset");

  a_lvr_resets: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lvr_hit |=> reset_o)
    else $error("low supply did not reset");

  a_mode_kept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wd_fire && !pin_low |=> $stable(mode_o))
    else $error("watchdog reset changed mode");

  a_sync_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    clr_sync && !(line_match && !match_d) |=> !sync_latch)
    else $error("sync latch not cleared by vector");

  a_por_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    por_busy |=> reset_o)
    else $error("reset released before power-on delay");

endmodule : reset_irq_ctrl
`default_nettype wire

// ==== verif/core_model.sv ====
/* core model: instruction ends, mask bit, trap and return pulses.
   assumes the block's take, vector and set-mask outputs on one clock. */
`timescale 1ns/1ps
`default_nettype none
module core_model
  import rst_irq_pkg::*;
(
  input  wire logic        clk_i,        // clock
  input  wire logic        reset_i,      // internal reset
  input  wire logic        take_i,       // take pulse
  input  wire logic [15:0] vector_i,     // vector taken
  input  wire logic        set_mask_i,   // set mask
  input  wire logic        hold_mask_i,  // keep mask set
  input  wire logic        slow_i,       // long instructions
  input  wire logic        trap_cmd_i,   // fetch a trap
  output logic             i_mask_o,     // mask bit
  output logic             boundary_o,   // instruction end
  output logic             trap_fetch_o, // trap fetched
  output logic             trap_exec_o,  // trap finishing
  output logic             rti_o         // return pulse
);
  logic       mask;
  logic [3:0] svc;
  logic [2:0] cnt;

  // --------
  // mask and routine
  // --------
  // routine or start-up code clears the mask eleven cycles after it was set
  always_ff @(posedge clk_i) begin
    rti_o <= 1'b0;
    if (set_mask_i) begin
      mask <= 1'b1;
      svc  <= 4'h0;
    end else if (mask && svc == 4'hA) begin
      mask  <= 1'b0;
      rti_o <= 1'b1;
    end else begin
      svc <= svc + 4'h1;
    end
  end
  assign i_mask_o = mask | hold_mask_i;

  // instruction ends, at least three cycles apart
  always_ff @(posedge clk_i) begin
    boundary_o <= (cnt == 3'h0) && !reset_i;
    if (reset_i || cnt == 3'h0)
      cnt <= slow_i ? 3'h6 : 3'h2;
    else
      cnt <= cnt - 3'h1;
  end

  // trap stays presented until its own vector is taken
  always_ff @(posedge clk_i) begin
    trap_fetch_o <= trap_cmd_i;
    if (reset_i || (take_i && vector_i == VEC_SOFT))
      trap_exec_o <= 1'b0;
    else if (trap_cmd_i)
      trap_exec_o <= 1'b1;
  end
endmodule : core_model
`default_nettype wire

// ==== verif/reset_and_interrupt_priority_logic_tb.sv ====
/* bench for reset_irq_ctrl with a core model and xorshift requests.
   assumes short counts: power-on 16 cycles, watchdog 64 cycles. */
`timescale 1ns/1ps
`default_nettype none
module reset_and_interrupt_priority_logic_tb
  import rst_irq_pkg::*;
;
  logic        clk_i, sys_rst_i, cyc_i, stb_i, we_i, ack_o, rst_pin_n_i, lvd_low_i;
  logic        mode_strap_i, irq_n_i, i_mask_i, boundary_i, trap_fetch_i, trap_exec_i;
  logic        rti_i, reset_o, take_o, set_mask_o, in_service_o, mode_o, hold, slow, trap_cmd;
  logic [15:0] adr_i, vector_o;
  logic [31:0] dat_i, dat_o, seed;
  logic [7:0]  nv_options_i, rd;
  logic [6:0]  line_counter_i;
  logic [3:0]  lvl, r;
  int          bad_count = 0, total_checks = 0, cycles = 0, n;

  reset_irq_ctrl #(.POR_COUNT(16), .WDOG_COUNT(64)) u_reset_irq_ctrl (
    .clk_i, .sys_rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF), .dat_i, .dat_o, .ack_o,
    .rst_pin_n_i, .lvd_low_i, .nv_options_i, .mode_strap_i, .irq_n_i, .line_counter_i,
    .timer_req_i(lvl[0]), .core_timer_source_req_i(lvl[1]), .serial_req_i(lvl[2]), .keypad_req_i(lvl[3]),
    .i_mask_i, .boundary_i, .trap_fetch_i, .trap_exec_i, .rti_i, .reset_o, .take_o,
    .vector_o, .set_mask_o, .in_service_o, .mode_o);
  core_model u_core_model (
    .clk_i, .reset_i(reset_o), .take_i(take_o), .vector_i(vector_o), .set_mask_i(set_mask_o),
    .hold_mask_i(hold), .slow_i(slow), .trap_cmd_i(trap_cmd), .i_mask_o(i_mask_i),
    .boundary_o(boundary_i), .trap_fetch_o(trap_fetch_i), .trap_exec_o(trap_exec_i),
    .rti_o(rti_i));

  // --------
  // helpers
  // --------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // timer outranks core timer, serial bus, then keypad
  function automatic logic [15:0] prio_vec(input logic [3:0] q);
    if (q[0]) return VEC_TIMER;
    if (q[1]) return VEC_CORE_TIMER_SOURCE;
    if (q[2]) return VEC_SERIAL;
    return VEC_KEYPAD;
  endfunction : prio_vec
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    chk("ack", 16'h1, {15'h0, k < 20});
  endtask : wb
  task automatic take_wait(input logic [15:0] v);
    int k;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (take_o !== 1'b1 && k < 300);
    chk("take with mask", 16'h1, {15'h0, take_o & set_mask_o});
    chk("vector", v, vector_o);
    @(negedge clk_i);
    chk("in service", 16'h1, {15'h0, in_service_o});
  endtask : take_wait
  // no reset (or no take) over c cycles
  task automatic quiet(input int c, input bit rst);
    int h;
    h = 0;
    repeat (c) begin
      @(negedge clk_i);
      if ((rst ? reset_o : take_o) !== 1'b0) h++;
    end
    chk(rst ? "reset quiet" : "take quiet", 16'h0, 16'(h));
  endtask : quiet
  task automatic rst_wait(input logic v, input int lim);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (reset_o !== v && n < lim);
    chk("reset_o", {15'h0, v}, {15'h0, reset_o});
  endtask : rst_wait
  task automatic pulse_irq();
    @(posedge clk_i);
    irq_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    irq_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : pulse_irq

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // --------
  // main sequence
  // --------
  initial begin
    {cyc_i, stb_i, we_i, adr_i, dat_i, lvd_low_i, nv_options_i, mode_strap_i} = '0;
    {line_counter_i, lvl, hold, slow, trap_cmd} = '0;
    {sys_rst_i, rst_pin_n_i, irq_n_i} = 3'h7;
    seed = 32'hC68251AB;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk("reset vector", VEC_RESET, vector_o);
    chk("reset mask", 16'h1, {15'h0, set_mask_o});
    rst_wait(1'b0, 60);
    chk("power-on length", 16'h1, {15'h0, n >= 17});
    wb(1'b0, 16'h0074, 8'h00);
    chk("option reset", 16'h0040, {8'h0, rd});
    wb(1'b0, 16'h0010, 8'h00);
    chk("unmapped read", 16'h0, {8'h0, rd});
    repeat (5) begin
      wb(1'b1, 16'hFFC0, 8'h00);
      quiet(40, 1'b1);
    end
    @(posedge clk_i);
    mode_strap_i <= 1'b1;
    rst_wait(1'b1, 80);
    chk("mode kept", 16'h0, {15'h0, mode_o});
    rst_wait(1'b0, 40);
    wb(1'b0, 16'h0074, 8'h00);
    chk("watchdog back on", 16'h0040, {8'h0, rd});
    wb(1'b1, 16'h0074, 8'h00);
    wb(1'b1, 16'h0074, 8'h40);
    quiet(200, 1'b1);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      r = seed[3:0] | 4'(1 << (i % 4));
      @(posedge clk_i);
      slow <= seed[4];
      lvl  <= r;
      while (r != 4'h0) begin
        take_wait(prio_vec(r));
        r = r & (r - 4'h1);
        @(posedge clk_i);
        lvl <= r;
      end
    end
    @(posedge clk_i);
    hold <= 1'b1;
    lvl  <= 4'h8;
    quiet(60, 1'b0);
    @(posedge clk_i);
    trap_cmd <= 1'b1;
    @(posedge clk_i);
    trap_cmd <= 1'b0;
    take_wait(VEC_SOFT);
    @(posedge clk_i);
    hold <= 1'b0;
    take_wait(VEC_KEYPAD);
    @(posedge clk_i);
    lvl <= 4'h0;
    wb(1'b1, 16'h0074, 8'h80);
    pulse_irq();
    take_wait(VEC_EXT);
    pulse_irq();
    pulse_irq();
    take_wait(VEC_EXT);
    quiet(60, 1'b0);
    wb(1'b1, 16'h0074, 8'h00);
    irq_n_i <= 1'b0;
    take_wait(VEC_EXT);
    take_wait(VEC_EXT);
    @(posedge clk_i);
    irq_n_i <= 1'b1;
    quiet(60, 1'b0);
    wb(1'b1, 16'h0038, 8'h85);
    line_counter_i <= 7'h05;
    take_wait(VEC_SYNC);
    quiet(60, 1'b0);
    @(posedge clk_i);
    rst_pin_n_i <= 1'b0;
    rst_wait(1'b1, 10);
    repeat (30) @(negedge clk_i);
    chk("pin reset held", 16'h1, {15'h0, reset_o});
    @(posedge clk_i);
    rst_pin_n_i <= 1'b1;
    rst_wait(1'b0, 12);
    wb(1'b1, 16'h0074, 8'h00);
    lvd_low_i <= 1'b1;
    quiet(20, 1'b1);
    @(posedge clk_i);
    nv_options_i <= 8'h01;
    rst_wait(1'b1, 10);
    @(posedge clk_i);
    lvd_low_i <= 1'b0;
    rst_wait(1'b0, 12);
    wb(1'b0, 16'h0080, 8'h00);
    chk("reset cause", 16'h0024, {8'h0, rd});
    report_and_stop();
  end
endmodule : reset_and_interrupt_priority_logic_tb
`default_nettype wire
